/* hw/forp_fmt.sv */
// forp_fmt: serialises one reading of four fields into bytes
// assumes byte_rdy stalls output; dump sends raw field bytes only
`timescale 1ns/10ps
`default_nettype none
module forp_fmt (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic [31:0] rdg,
  input  wire logic        dump,
  input  wire logic [7:0]  sep,
  input  wire logic [7:0]  term,
  input  wire logic        byte_rdy,
  output logic             byte_vld,
  output logic [7:0]       byte_out,
  output logic             busy
);
  // step 0..3 fields, 4 term, then done; separators between fields
  logic [3:0] step_q;
  logic       sep_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      step_q   <= 4'h0;
      sep_q    <= 1'b0;
      busy     <= 1'b0;
      byte_vld <= 1'b0;
      byte_out <= 8'h00;
    end else if (go && !busy) begin
      busy     <= 1'b1;
      step_q   <= 4'h0;
      sep_q    <= 1'b0;
      byte_vld <= 1'b1;
      byte_out <= rdg[31:24]; // frequency field first
    end else if (busy && byte_vld && byte_rdy) begin
      if (!dump && !sep_q && step_q < 4'h3) begin
        sep_q    <= 1'b1;
        byte_out <= sep;
      end else if (step_q < 4'h3) begin
        sep_q    <= 1'b0;
        step_q   <= step_q + 4'h1;
        byte_out <= rdg[8'(23 - 8 * step_q) -: 8];
      end else if (!dump && step_q == 4'h3) begin
        step_q   <= 4'h4;
        byte_out <= term;
      end else begin
        busy     <= 1'b0;
        byte_vld <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* hw/forp_pace.sv */
// forp_pace: one-cycle enable after a chosen number of cycles
// assumes start restarts the count
`timescale 1ns/10ps
`default_nettype none
module forp_pace #(
  parameter int NORM_CYC = forp_pkg::NORM_PACE_CYC,
  parameter int DUMP_CYC = forp_pkg::DUMP_PACE_CYC
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic dump,
  output logic      tick
);
  // a load of zero would never reach the tick value and hang a listing
  if (NORM_CYC < 2 || DUMP_CYC < 2) begin
    $error("pace counts must be at least 2");
  end
  logic [31:0] cnt_q;
  // ------------------------------------------------------------
  // down counter, reload on start
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= 32'h0;
    end else if (start) begin
      cnt_q <= dump ? 32'(DUMP_CYC - 1) : 32'(NORM_CYC - 1);
    end else if (cnt_q != 32'h0) begin
      cnt_q <= cnt_q - 32'h1;
    end
  end
  assign tick = (cnt_q == 32'h1);
endmodule
`default_nettype wire

/* hw/forp_pkg.sv */
// forp_pkg: shared constants and types for the file output and plot router
// assumes nothing beyond a 40 MHz mclk
package forp_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ          = 40_000_000;
  localparam int NORM_PACE_MS    = 40;
  localparam int DUMP_PACE_MS    = 12;
  localparam int NORM_PACE_CYC   = CLK_HZ / 1000 * NORM_PACE_MS;
  localparam int DUMP_PACE_CYC   = CLK_HZ / 1000 * DUMP_PACE_MS;

  // ------------------------------------------------------------
  // routing and commands
  // ------------------------------------------------------------
  localparam logic [1:0] ROUTE_OFF   = 2'h0;
  localparam logic [1:0] ROUTE_ALL   = 2'h1;
  localparam logic [1:0] SER_RST     = 2'h0;
  localparam logic [1:0] GPIB_RST    = 2'h0;
  localparam logic [1:0] PORT_SER    = 2'h1;
  localparam logic [1:0] PORT_GPIB   = 2'h2;
  localparam logic [7:0] SEP_COMMA   = 8'h2C;
  localparam logic [7:0] TERM_CR     = 8'h0D;
  localparam logic [7:0] TERM_LF     = 8'h0A;
  localparam int         EOP_BIT     = 7;

  typedef enum logic [2:0] {
    FORP_CMD_NONE  = 3'h0,
    FORP_CMD_ROUTE = 3'h1,
    FORP_CMD_LIST  = 3'h2,
    FORP_CMD_COUNT = 3'h3,
    FORP_CMD_FIRST = 3'h4,
    FORP_CMD_STEP  = 3'h5,
    FORP_CMD_PLOT  = 3'h6
  } forp_cmd_t;

  typedef struct packed {
    forp_cmd_t  cmd;
    logic       from_gpib;
    logic [1:0] arg_port;
    logic [1:0] arg_mode;
  } forp_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic       to_ser;
    logic       to_gpib;
  } forp_byte_t;
endpackage

/* hw/forp_top.sv */
// forp_top: command interpreter for reading-store readout and plot routing
// assumes one decoded command pulse at a time, store read with one-cycle latency
// Behaviour
// - route command 1,1 sets serial routing to all readings
// - list command sends every stored reading to each port that routing and talk mode select for the requester
// - free listing paces readings 40 ms normal, 12 ms dump
// - non-dump readings carry selected separators and terminator
// - route command 2,1 sets GPIB routing to all readings
// - count query replies with number of stored readings
// - first-reading command sends reading one, fields in fixed order
// - each step-down short of the last reading advances pointer one and sends that reading
// - GPIB routing resets off; while off only plot bytes reach GPIB
// - plot bytes use comma separators and CR LF terminator
// - when configured, plot end sets status bit 7 and requests service
// - GPIB-requested data is copied to serial unless serial routing off
// - talk-only sends serial-requested data on GPIB if GPIB routing on
// - talker/listener never sends serial-requested data onto GPIB
`timescale 1ns/10ps
`default_nettype none
module forp_top #(
  parameter int ADDR_W   = 8,
  parameter int NORM_CYC = forp_pkg::NORM_PACE_CYC,
  parameter int DUMP_CYC = forp_pkg::DUMP_PACE_CYC
) (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                cmd_vld,
  input  wire forp_pkg::forp_req_t cmd_req,
  input  wire logic                dump_mode,
  input  wire logic                talk_only,
  input  wire logic                srq_plot_cfg,
  input  wire logic [7:0]          sel_sep,
  input  wire logic [7:0]          sel_term,
  input  wire logic [ADDR_W-1:0]   store_count,
  output logic [ADDR_W-1:0]        store_addr,
  input  wire logic [31:0]         store_data,
  input  wire logic                plot_vld,
  input  wire logic [7:0]          plot_data,
  input  wire logic                plot_last,
  output logic                     plot_rdy,
  input  wire logic                out_rdy,
  output var forp_pkg::forp_byte_t out_byte,
  output logic                     out_vld,
  output logic                     count_vld,
  output logic [ADDR_W-1:0]        count_out,
  output logic [1:0]               ser_route,
  output logic [1:0]               gpib_route,
  input  wire logic                status_clr,
  output logic [7:0]               status_byte,
  output logic                     srq
);
  if (ADDR_W < 1 || ADDR_W > 16) begin
    $error("ADDR_W out of range");
  end

  typedef enum logic [2:0] {
    FORP_IDLE  = 3'h0,
    FORP_FETCH = 3'h1,
    FORP_SEND  = 3'h2,
    FORP_WAIT  = 3'h3,
    FORP_PLOT  = 3'h4
  } forp_st_t;

  forp_st_t          st_q;
  logic [ADDR_W-1:0] ptr_q;
  logic              list_q;
  logic              req_gpib_q;
  logic              fmt_go;
  logic              fmt_vld;
  logic              fmt_busy;
  logic [7:0]        fmt_byte;
  logic              pace_tick;
  logic              dst_ser;
  logic              dst_gpib;
  logic              eop_q;
  logic              cmd_ok;
  logic              go_q;

  // destination of one data unit given its requesting port
  function automatic logic [1:0] dest(input logic from_gpib, input logic [1:0] sr,
                                      input logic [1:0] gr, input logic tonly);
    logic s;
    logic g;
    s = 1'b0;
    g = 1'b0;
    if (from_gpib) begin
      g = (gr != forp_pkg::ROUTE_OFF);
      s = (sr != forp_pkg::ROUTE_OFF);
    end else begin
      s = (sr != forp_pkg::ROUTE_OFF);
      g = tonly && (gr != forp_pkg::ROUTE_OFF);
    end
    return {s, g};
  endfunction

  assign cmd_ok = cmd_vld && (st_q == FORP_IDLE);
  assign {dst_ser, dst_gpib} = dest(req_gpib_q, ser_route, gpib_route, talk_only);

  // ------------------------------------------------------------
  // routing settings
  // ------------------------------------------------------------
  // kept apart so one port can be silenced while the other lists
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ser_route  <= forp_pkg::SER_RST;
      gpib_route <= forp_pkg::GPIB_RST;
    end else if (cmd_ok && cmd_req.cmd == forp_pkg::FORP_CMD_ROUTE) begin
      if (cmd_req.arg_port == forp_pkg::PORT_SER) begin
        ser_route <= cmd_req.arg_mode;
      end else if (cmd_req.arg_port == forp_pkg::PORT_GPIB) begin
        gpib_route <= cmd_req.arg_mode;
      end
    end
  end

  // ------------------------------------------------------------
  // count query reply
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_vld <= 1'b0;
      count_out <= '0;
    end else begin
      count_vld <= cmd_ok && cmd_req.cmd == forp_pkg::FORP_CMD_COUNT;
      if (cmd_ok && cmd_req.cmd == forp_pkg::FORP_CMD_COUNT) begin
        count_out <= store_count;
      end
    end
  end

  // ------------------------------------------------------------
  // readout sequencer
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q       <= FORP_IDLE;
      ptr_q      <= '0;
      list_q     <= 1'b0;
      req_gpib_q <= 1'b0;
    end else begin
      unique case (st_q)
        FORP_IDLE: begin
          if (cmd_ok) begin
            req_gpib_q <= cmd_req.from_gpib;
            unique case (cmd_req.cmd)
              forp_pkg::FORP_CMD_LIST: begin
                ptr_q  <= '0;
                list_q <= 1'b1;
                if (store_count != '0) st_q <= FORP_FETCH;
              end
              forp_pkg::FORP_CMD_FIRST: begin
                ptr_q  <= '0;
                list_q <= 1'b0;
                if (store_count != '0) st_q <= FORP_FETCH;
              end
              forp_pkg::FORP_CMD_STEP: begin
                list_q <= 1'b0;
                if (ptr_q + ADDR_W'(1) < store_count) begin
                  ptr_q <= ptr_q + ADDR_W'(1);
                  st_q  <= FORP_FETCH;
                end
              end
              forp_pkg::FORP_CMD_PLOT: st_q <= FORP_PLOT;
              default: ;
            endcase
          end
        end
        FORP_FETCH: st_q <= FORP_SEND;
        FORP_SEND: begin
          if (fmt_busy && fmt_vld && out_rdy && !dump_mode && fmt_byte == sel_term) begin
            st_q <= FORP_SEND;
          end
          if (!fmt_busy && !fmt_go) begin
            if (list_q && ptr_q + ADDR_W'(1) < store_count) begin
              st_q <= FORP_WAIT;
            end else begin
              st_q <= FORP_IDLE;
            end
          end
        end
        FORP_WAIT: begin
          if (pace_tick) begin
            ptr_q <= ptr_q + ADDR_W'(1);
            st_q  <= FORP_FETCH;
          end
        end
        FORP_PLOT: begin
          if (plot_vld && plot_rdy && plot_last) st_q <= FORP_IDLE;
        end
        default: st_q <= FORP_IDLE;
      endcase
    end
  end

  assign store_addr = ptr_q;

  // capture a cycle after fetch: the store answers one cycle after the address,
  // so starting the formatter in fetch would take the previous reading's first byte
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      go_q <= 1'b0;
    end else begin
      go_q <= (st_q == FORP_FETCH);
    end
  end
  assign fmt_go     = go_q;

  forp_pace #(
    .NORM_CYC (NORM_CYC),
    .DUMP_CYC (DUMP_CYC)
  ) u_pace (
    .mclk  (mclk),
    .rst   (rst),
    .start (fmt_go),
    .dump  (dump_mode),
    .tick  (pace_tick)
  );

  forp_fmt u_fmt (
    .mclk     (mclk),
    .rst      (rst),
    .go       (fmt_go),
    .rdg      (store_data),
    .dump     (dump_mode),
    .sep      (sel_sep),
    .term     (sel_term),
    .byte_rdy (out_rdy),
    .byte_vld (fmt_vld),
    .byte_out (fmt_byte),
    .busy     (fmt_busy)
  );

  // ------------------------------------------------------------
  // output mux: readings or plot bytes
  // ------------------------------------------------------------
  // plot bytes bypass gpib routing; the generator formats them with commas/crlf
  always_comb begin
    out_byte = '0;
    out_vld  = 1'b0;
    plot_rdy = 1'b0;
    if (st_q == FORP_PLOT) begin
      plot_rdy         = out_rdy;
      out_vld          = plot_vld;
      out_byte.data    = plot_data;
      out_byte.to_gpib = 1'b1;
    end else if (st_q == FORP_SEND && fmt_vld) begin
      out_vld          = dst_ser || dst_gpib;
      out_byte.data    = fmt_byte;
      out_byte.to_ser  = dst_ser;
      out_byte.to_gpib = dst_gpib;
    end
  end

  // ------------------------------------------------------------
  // end of plot status
  // ------------------------------------------------------------
  // set wins over a clear in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      eop_q <= 1'b0;
    end else if (st_q == FORP_PLOT && plot_vld && plot_rdy && plot_last && srq_plot_cfg) begin
      eop_q <= 1'b1;
    end else if (status_clr) begin
      eop_q <= 1'b0;
    end
  end
  assign status_byte = {eop_q, 7'h00};
  assign srq         = eop_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_gpib_rst_off: assert property (@(posedge mclk)
    $fell(rst) |-> gpib_route == forp_pkg::ROUTE_OFF)
    else $error("gpib route not off after reset");
  chk_route_ser: assert property (@(posedge mclk) disable iff (rst)
    cmd_ok && cmd_req.cmd == forp_pkg::FORP_CMD_ROUTE && cmd_req.arg_port == forp_pkg::PORT_SER
    |=> ser_route == $past(cmd_req.arg_mode)) else $error("serial route not set");
  chk_route_gpib: assert property (@(posedge mclk) disable iff (rst)
    cmd_ok && cmd_req.cmd == forp_pkg::FORP_CMD_ROUTE && cmd_req.arg_port == forp_pkg::PORT_GPIB
    |=> gpib_route == $past(cmd_req.arg_mode)) else $error("gpib route not set");
  chk_count_reply: assert property (@(posedge mclk) disable iff (rst)
    cmd_ok && cmd_req.cmd == forp_pkg::FORP_CMD_COUNT
    |=> count_vld && count_out == $past(store_count)) else $error("count reply wrong");
  chk_first_ptr: assert property (@(posedge mclk) disable iff (rst)
    cmd_ok && cmd_req.cmd == forp_pkg::FORP_CMD_FIRST && store_count != '0
    |=> st_q == FORP_FETCH && ptr_q == '0) else $error("first reading not fetched");
  chk_step_adv: assert property (@(posedge mclk) disable iff (rst)
    cmd_ok && cmd_req.cmd == forp_pkg::FORP_CMD_STEP && ptr_q + ADDR_W'(1) < store_count
    |=> ptr_q == $past(ptr_q) + ADDR_W'(1)) else $error("step did not advance");
  chk_ser_tl_block: assert property (@(posedge mclk) disable iff (rst)
    st_q == FORP_SEND && !req_gpib_q && !talk_only |-> !out_byte.to_gpib)
    else $error("serial data on gpib");
  chk_gpib_copy: assert property (@(posedge mclk) disable iff (rst)
    st_q == FORP_SEND && fmt_vld && req_gpib_q && ser_route != forp_pkg::ROUTE_OFF
    |-> out_byte.to_ser) else $error("gpib data not copied");
  chk_only_plot: assert property (@(posedge mclk) disable iff (rst)
    out_vld && gpib_route == forp_pkg::ROUTE_OFF && out_byte.to_gpib |-> st_q == FORP_PLOT)
    else $error("non-plot byte on gpib");
  chk_eop_srq: assert property (@(posedge mclk) disable iff (rst)
    st_q == FORP_PLOT && plot_vld && plot_rdy && plot_last && srq_plot_cfg
    |=> srq && status_byte[forp_pkg::EOP_BIT]) else $error("end of plot not flagged");
  chk_pace_wait: assert property (@(posedge mclk) disable iff (rst)
    $rose(st_q == FORP_WAIT) |=> st_q == FORP_WAIT) else $error("listing paced too fast");
  // a fetch must be followed by the capture cycle, else the first byte is stale
  chk_fetch_align: assert property (@(posedge mclk) disable iff (rst)
    st_q == FORP_FETCH |=> st_q == FORP_SEND && go_q) else $error("fetch not aligned");
  chk_busy_refuse: assert property (@(posedge mclk) disable iff (rst)
    cmd_vld && st_q != FORP_IDLE |=> $stable(ser_route) && $stable(gpib_route))
    else $error("route changed while busy");
  chk_eop_cfg_off: assert property (@(posedge mclk) disable iff (rst)
    !srq_plot_cfg && !eop_q |=> !eop_q) else $error("end of plot flagged unarmed");
  chk_eop_hold: assert property (@(posedge mclk) disable iff (rst)
    eop_q && !status_clr |=> eop_q) else $error("end of plot flag lost");
  cov_list: cover property (@(posedge mclk) disable iff (rst)
    st_q == FORP_WAIT ##1 st_q == FORP_FETCH);
  cov_step: cover property (@(posedge mclk) disable iff (rst)
    cmd_ok && cmd_req.cmd == forp_pkg::FORP_CMD_STEP);
  cov_plot: cover property (@(posedge mclk) disable iff (rst) $rose(srq));
  cov_dump_wait: cover property (@(posedge mclk) disable iff (rst)
    st_q == FORP_WAIT && dump_mode);
  cov_both_ports: cover property (@(posedge mclk) disable iff (rst)
    out_vld && out_byte.to_ser && out_byte.to_gpib);
endmodule
`default_nettype wire

/* tb/forp_far_model.sv */
// forp_far_model: reading store and output sink beside the router
// assumes the bench loads the store before any readout command
`timescale 1ns/10ps
`default_nettype none
module forp_far_model #(
  parameter int ADDR_W = 8
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [31:0]       wr_data,
  input  wire logic              slow,
  input  wire logic [ADDR_W-1:0] store_addr,
  output logic [31:0]            store_data,
  output logic                   out_rdy
);
  // ------------------------------------------------------------
  // reading store and sink
  // ------------------------------------------------------------
  logic [31:0] mem_q [0:(1<<ADDR_W)-1];
  logic [7:0]  lfsr_q;

  // one-cycle read latency, the router relies on it
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
    store_data <= mem_q[store_addr];
  end

  // slow mode stalls often; a slow controller only meets it
  // through the stepwise readout, never the free listing
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lfsr_q  <= 8'hA5;
      out_rdy <= 1'h0;
    end else begin
      lfsr_q  <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      out_rdy <= slow ? lfsr_q[0] : 1'h1;
    end
  end
endmodule
`default_nettype wire

/* tb/forp_top_tb.sv */
// forp_top_tb: self-checking bench for the file output and plot router
// assumes forp_pkg, forp_top and forp_far_model are compiled first
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) begin \
      fails++; \
      $display("unexpected %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module forp_top_tb;
  localparam int AW = 8;
  localparam int NORM = 50;
  localparam int DUMP = 20;
  localparam int NRDG = 6;
  localparam int LIMIT = 20000;
  logic                 mclk, rst, cmd_vld, dump_mode, talk_only, srq_plot_cfg;
  logic                 plot_vld, plot_last, plot_rdy, out_rdy, out_vld, count_vld;
  logic                 srq, status_clr, wr_en, slow;
  logic [7:0]           sel_sep, sel_term, plot_data, status_byte;
  logic [AW-1:0]        store_count, store_addr, count_out, wr_addr;
  logic [31:0]          store_data, wr_data;
  logic [1:0]           ser_route, gpib_route;
  forp_pkg::forp_req_t  cmd_req;
  forp_pkg::forp_byte_t out_byte;
  forp_pkg::forp_byte_t exp_b;
  logic [31:0]          rdg [0:NRDG-1];
  forp_pkg::forp_byte_t expq[$];
  bit                   headq[$];
  int                   fails, num_checks, cyc, last_head, pace_exp, seed, counts;

  forp_top #(.ADDR_W(AW), .NORM_CYC(NORM), .DUMP_CYC(DUMP)) dut_u (
    .mclk(mclk), .rst(rst), .cmd_vld(cmd_vld), .cmd_req(cmd_req),
    .dump_mode(dump_mode), .talk_only(talk_only), .srq_plot_cfg(srq_plot_cfg),
    .sel_sep(sel_sep), .sel_term(sel_term), .store_count(store_count),
    .store_addr(store_addr), .store_data(store_data), .plot_vld(plot_vld),
    .plot_data(plot_data), .plot_last(plot_last), .plot_rdy(plot_rdy),
    .out_rdy(out_rdy), .out_byte(out_byte), .out_vld(out_vld),
    .count_vld(count_vld), .count_out(count_out), .ser_route(ser_route),
    .gpib_route(gpib_route), .status_clr(status_clr),
    .status_byte(status_byte), .srq(srq));

  forp_far_model #(.ADDR_W(AW)) far_u (
    .mclk(mclk), .rst(rst), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .slow(slow), .store_addr(store_addr), .store_data(store_data), .out_rdy(out_rdy));

  // ------------------------------------------------------------
  // clock, watchdog and output monitor
  // ------------------------------------------------------------
  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end

  // a hang counts as a mismatch and closes the run
  initial begin
    cyc = 0;
    forever begin
      @(posedge mclk);
      cyc++;
      if (cyc == LIMIT) begin
        fails++;
        $display("unexpected timeout expected done seen %0d cycles", cyc);
        end_of_test();
      end
    end
  end

  // pops the oldest note on each accepted byte; pre-edge values are sampled
  always @(posedge mclk) begin
    if (!rst && count_vld) begin
      counts++;
      `CHK("count_out", store_count, count_out)
    end
    if (!rst && out_vld && out_rdy) begin
      if (expq.size() == 0) begin
        fails++;
        $display("unexpected out_byte expected none seen %0h", out_byte);
      end else begin
        // pop once: the compare macro reads its expected value twice
        exp_b = expq.pop_front();
        `CHK("out_byte", exp_b, out_byte)
        if (headq.pop_front()) begin
          if (pace_exp > 0 && last_head >= 0) begin
            `CHK("pace", 1'h1, ((cyc - last_head) >= pace_exp))
          end
          last_head = cyc;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // driver tasks
  // ------------------------------------------------------------
  task automatic cmd(input forp_pkg::forp_cmd_t c, input logic g, input logic [1:0] p, m);
    @(posedge mclk);
    cmd_vld <= 1'h1;
    cmd_req <= '{cmd: c, from_gpib: g, arg_port: p, arg_mode: m};
    @(posedge mclk);
    cmd_vld <= 1'h0;
  endtask

  // notes one reading; dump keeps only the four raw fields
  task automatic exp_rdg(input int i, input logic ts, tg);
    logic [7:0] b [0:7];
    b = '{rdg[i][31:24], sel_sep, rdg[i][23:16], sel_sep, rdg[i][15:8], sel_sep,
          rdg[i][7:0], sel_term};
    for (int k = 0; k < 8; k++) begin
      if (!dump_mode || (k % 2) == 0) begin
        expq.push_back('{data: b[k], to_ser: ts, to_gpib: tg});
        headq.push_back(k == 0);
      end
    end
  endtask

  // bounded wait for the notes to drain, then a fixed settle
  task automatic drain(input int n);
    int k;
    k = 0;
    while (expq.size() != 0 && k < 3000) begin
      @(posedge mclk);
      k++;
    end
    `CHK("drain", 0, expq.size())
    repeat (n) @(posedge mclk);
  endtask

  // held until plot_rdy is seen high at an edge
  task automatic plot_put(input logic [7:0] d, input logic last);
    int k;
    expq.push_back('{data: d, to_ser: 1'h0, to_gpib: 1'h1});
    headq.push_back(1'b0);
    plot_vld  <= 1'h1;
    plot_data <= d;
    plot_last <= last;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (plot_rdy !== 1'h1 && k < 200);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 5817;
    {cmd_vld, dump_mode, talk_only, srq_plot_cfg, plot_vld, plot_last} = '0;
    {status_clr, wr_en, slow, plot_data, wr_addr, wr_data} = '0;
    cmd_req = '0;
    sel_sep = 8'h3B;
    sel_term = 8'h0D;
    store_count = AW'(NRDG);
    {fails, num_checks, pace_exp, counts} = '0;
    last_head = -1;
    rst = 1'h1;
    repeat (5) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    `CHK("gpib_route", forp_pkg::GPIB_RST, gpib_route)
    `CHK("ser_route", forp_pkg::SER_RST, ser_route)
    `CHK("status_byte", 8'h00, {status_byte, srq})
    for (int i = 0; i < NRDG; i++) begin
      rdg[i] = $random(seed);
      wr_en   <= 1'h1;
      wr_addr <= AW'(i);
      wr_data <= rdg[i];
      @(posedge mclk);
    end
    wr_en <= 1'h0;
    // local mode is implied from reset onward, so commands may start
    cmd(forp_pkg::FORP_CMD_COUNT, 1'h1, 2'h0, 2'h0);
    drain(2);
    `CHK("count pulses", 1, counts)
    cmd(forp_pkg::FORP_CMD_ROUTE, 1'h1, forp_pkg::PORT_GPIB, forp_pkg::ROUTE_ALL);
    drain(2);
    `CHK("gpib_route", forp_pkg::ROUTE_ALL, gpib_route)
    `CHK("ser_route", forp_pkg::ROUTE_OFF, ser_route)
    // stepwise readout against a stalling sink, then one step too many
    slow <= 1'h1;
    exp_rdg(0, 1'h0, 1'h1);
    cmd(forp_pkg::FORP_CMD_FIRST, 1'h1, 2'h0, 2'h0);
    drain(4);
    for (int i = 1; i <= NRDG; i++) begin
      if (i < NRDG) exp_rdg(i, 1'h0, 1'h1);
      cmd(forp_pkg::FORP_CMD_STEP, 1'h1, 2'h0, 2'h0);
      drain(8);
    end
    slow <= 1'h0;
    cmd(forp_pkg::FORP_CMD_ROUTE, 1'h0, forp_pkg::PORT_SER, forp_pkg::ROUTE_ALL);
    drain(2);
    `CHK("ser_route", forp_pkg::ROUTE_ALL, ser_route)
    exp_rdg(0, 1'h1, 1'h1);
    cmd(forp_pkg::FORP_CMD_FIRST, 1'h1, 2'h0, 2'h0);
    drain(4);
    // serial-requested listings, talker/listener then talk-only dump
    for (int t = 0; t < 2; t++) begin
      talk_only <= t[0];
      dump_mode <= t[0];
      @(posedge mclk);
      pace_exp = t[0] ? DUMP : NORM;
      last_head = -1;
      for (int i = 0; i < NRDG; i++) exp_rdg(i, 1'h1, t[0]);
      cmd(forp_pkg::FORP_CMD_LIST, 1'h0, 2'h0, 2'h0);
      // a route change while busy is refused silently
      cmd(forp_pkg::FORP_CMD_ROUTE, 1'h0, forp_pkg::PORT_SER, forp_pkg::ROUTE_OFF);
      drain(NORM + 10);
      `CHK("ser_route busy", forp_pkg::ROUTE_ALL, ser_route)
    end
    pace_exp = 0;
    store_count <= '0;
    cmd(forp_pkg::FORP_CMD_LIST, 1'h1, 2'h0, 2'h0);
    drain(NORM + 10);
    store_count <= AW'(NRDG);
    cmd(forp_pkg::FORP_CMD_ROUTE, 1'h1, forp_pkg::PORT_SER, forp_pkg::ROUTE_OFF);
    cmd(forp_pkg::FORP_CMD_ROUTE, 1'h1, forp_pkg::PORT_GPIB, forp_pkg::ROUTE_OFF);
    drain(2);
    `CHK("routes off", 4'h0, {ser_route, gpib_route})
    // plot: end-of-plot service request armed first
    srq_plot_cfg <= 1'h1;
    cmd(forp_pkg::FORP_CMD_PLOT, 1'h1, 2'h0, 2'h0);
    plot_put(8'h31, 1'h0);
    plot_put(forp_pkg::SEP_COMMA, 1'h0);
    plot_put(8'h32, 1'h0);
    plot_put(forp_pkg::TERM_CR, 1'h0);
    plot_put(forp_pkg::TERM_LF, 1'h1);
    plot_vld <= 1'h0;
    drain(0);
    // serial poll until end of plot shows
    for (int k = 0; k < 50 && status_byte[forp_pkg::EOP_BIT] !== 1'h1; k++) @(posedge mclk);
    `CHK("status_byte", 8'h80, status_byte)
    `CHK("srq", 1'h1, srq)
    status_clr <= 1'h1;
    @(posedge mclk);
    status_clr <= 1'h0;
    @(posedge mclk);
    @(posedge mclk);
    `CHK("status cleared", 9'h000, {status_byte, srq})
    end_of_test();
  end
endmodule
`default_nettype wire
